// >>> hw/pic_pkg.sv
// pic_pkg: constants, register map and types of the interrupt controller
// assumes: 20 MHz system clock, AXI4-Lite register access with 32-bit data
package pic_pkg;

    // ************
    // sizes
    // ************
    localparam int NUM_PRIO = 26;
    localparam int IDX_W    = 5;
    localparam int ADDR_W   = 12;
    localparam int CNT_W    = 4;

    typedef logic [IDX_W-1:0] pic_prio_t;

    // ************
    // register indices, byte address is four times the index
    // ************
    localparam logic [7:0] IDX_CLR0 = 8'hDA;
    localparam logic [7:0] IDX_CLR1 = 8'hDB;
    localparam logic [7:0] IDX_CLR2 = 8'hDC;
    localparam logic [7:0] IDX_MSK3 = 8'hDE;
    localparam logic [7:0] IDX_MSK2 = 8'hDF;
    localparam logic [7:0] IDX_MSK0 = 8'hE0;
    localparam logic [7:0] IDX_MSK1 = 8'hE1;
    localparam logic [7:0] IDX_VC   = 8'hE2;

    localparam logic [7:0] CLR_IDX [3] = '{IDX_CLR0, IDX_CLR1, IDX_CLR2};
    localparam logic [7:0] MSK_IDX [3] = '{IDX_MSK0, IDX_MSK1, IDX_MSK2};

    // ************
    // bit position to priority, 0 marks a reserved bit
    // ************
    localparam pic_prio_t BYTE_MAP [3][8] = '{
        '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h19, 5'h06},
        '{5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h00},
        '{5'h00, 5'h11, 5'h12, 5'h00, 5'h14, 5'h00, 5'h00, 5'h00}
    };

    // priorities 1-14, 17, 18, 20, 25 exist; 0 is reset, never posted
    localparam logic [NUM_PRIO-1:0] SRC_VALID = 26'h2167FFE;

    // ************
    // field positions and encodings
    // ************
    localparam int SOFT_POST_BIT = 7;
    localparam int GIE_BIT       = 0;
    localparam int VEC_SHIFT     = 2;
    localparam logic [7:0] PC_HIGH_ZERO = 8'h00;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    // ************
    // dispatch timing in cpu cycles
    // ************
    localparam logic [CNT_W-1:0] DISPATCH_CYCLES = 4'hD;
    localparam logic [CNT_W-1:0] LONG_JUMP_INSTR_CYCLES     = 4'h7;
    localparam logic [CNT_W-1:0] PUSH_PCH_CYC    = 4'h1;
    localparam logic [CNT_W-1:0] PUSH_PCL_CYC    = 4'h2;
    localparam logic [CNT_W-1:0] PUSH_FLAGS_CYC  = 4'h3;
    localparam logic [CNT_W-1:0] FLAGS_CLR_CYC   = 4'h4;
    localparam logic [CNT_W-1:0] CNT_ONE         = 4'h1;

    typedef enum logic [1:0] {
        SEQ_IDLE     = 2'b00,
        SEQ_DISPATCH = 2'b01,
        SEQ_JUMP     = 2'b11
    } pic_seq_t;

    typedef struct packed {
        logic        push_valid;
        logic [7:0]  push_data;
        logic        flags_clear;
        logic        pc_load;
        logic [15:0] pc_value;
        logic        service_start;
        logic        dispatching;
    } pic_cpu_ctl_t;

endpackage

// >>> hw/pic_prio_enc.sv
// pic_prio_enc: picks the lowest-numbered set request
// assumes: pending requests come from flops on the same clock
`timescale 1ns/1ps
`default_nettype none

module pic_prio_enc #(
    parameter int N     = 26,
    parameter int IDX_W = 5
) (
    // requests
    input  wire logic [N-1:0]     pending,
    // result
    output logic                  found,
    output logic [IDX_W-1:0]      index
);

    // ************
    // scan from low priority up, so the last hit is the highest
    // ************
    always_comb begin
        found = 1'b0;
        index = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pending[i]) begin
                found = 1'b1;
                index = IDX_W'(i);
            end
        end
    end

endmodule // pic_prio_enc

`default_nettype wire

// >>> hw/pic_ctrl.sv
// pic_ctrl: posted flags, masks, priority choice and cpu dispatch sequencing
// assumes: sources pulse on sys_clk; cpu core gives instruction boundaries
// Summary of operation
// - source event sets posted flag until taken
// - only masked-in posted flags are pending
// - highest pending taken while global enable set
// - mask clear keeps posted flag and posting
// - vector is four times priority, 0 to 14
// - priorities 17,18,20,25 used, others reserved
// - event, mask write or enable rise activates
// - finish instruction then 13-cycle dispatch
// - push pc high, pc low, flags
// - clear flags after stacking, enable off
// - pc high zero, pc low gets vector
// - return restores pc and flags
// - pending requests served before next instruction
// - latency: rest, 13 dispatch, 7 jump
// - enable set in service allows nesting
// - clear register read shows posted flags
// - write 0 clears if soft post off; 1 posts if on
// - clear register 0 bit layout
// - clear register 1 bit layout
// - clear register 2 bit layout
// - four mask registers, one bit each
// - vector register read vector, write clears
// - soft post ignores zeros, else ones
// - mask register 0 layout, reset zero
// - mask registers 1 and 2 layout
`timescale 1ns/1ps
`default_nettype none

module pic_ctrl #(
    parameter int NUM_PRIO = pic_pkg::NUM_PRIO
) (
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    // interrupt sources, one-cycle pulses per priority
    input  wire logic [NUM_PRIO-1:0]           src_event,
    // cpu core side
    input  wire logic                          instr_done,
    input  wire logic                          return_from_irq_instr_done,
    input  wire logic [7:0]                    return_from_irq_instr_flags,
    input  wire logic [7:0]                    cpu_flags,
    input  wire logic [15:0]                   cpu_program_counter,
    output logic                               irq_request,
    output logic [7:0]                         irq_vector,
    output pic_pkg::pic_cpu_ctl_t              cpu_ctl,
    // axi4-lite write address and data
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [pic_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    // axi4-lite write response
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    output logic [1:0]                         s_axi_bresp,
    // axi4-lite read
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    input  wire logic [pic_pkg::ADDR_W-1:0]    s_axi_araddr,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp
);

    // ************
    // declarations
    // ************
    logic [NUM_PRIO-1:0]           posted;
    logic [NUM_PRIO-1:0]           next_posted;
    logic [NUM_PRIO-1:0]           irq_enable_regs;
    logic                          soft_post_enable;
    logic [NUM_PRIO-1:0]           pending;
    logic [NUM_PRIO-1:0]           sw_clr;
    logic [NUM_PRIO-1:0]           sw_set;
    logic [NUM_PRIO-1:0]           vc_clr;
    logic [NUM_PRIO-1:0]           ack_clr;
    logic                          enc_found;
    pic_pkg::pic_prio_t            enc_index;
    logic [7:0]                    cur_vector;
    logic [7:0]                    clr_img [3];
    logic [7:0]                    msk_img [3];

    logic                          aw_held;
    logic                          w_held;
    logic [pic_pkg::ADDR_W-1:0]    wr_addr;
    logic [7:0]                    wr_byte;
    logic                          wr_lane;
    logic                          wr_fire;
    logic                          wr_vc;
    logic [7:0]                    rd_byte;
    logic                          rd_hit;

    pic_pkg::pic_seq_t             seq_state;
    logic [pic_pkg::CNT_W-1:0]     seq_cnt;
    logic [7:0]                    held_vector;
    logic [15:0]                   held_pc;
    logic [7:0]                    held_flags;
    logic                          boundary;
    logic                          gie_now;
    logic                          take_fire;

    // ************
    // address helpers
    // ************
    function automatic logic is_reg(input logic [pic_pkg::ADDR_W-1:0] addr,
                                    input logic [7:0] idx);
        is_reg = (addr[pic_pkg::ADDR_W-1:2] == {2'b00, idx});
    endfunction

    function automatic logic is_mapped(input logic [pic_pkg::ADDR_W-1:0] addr);
        is_mapped = is_reg(addr, pic_pkg::IDX_CLR0) | is_reg(addr, pic_pkg::IDX_CLR1)
                  | is_reg(addr, pic_pkg::IDX_CLR2) | is_reg(addr, pic_pkg::IDX_MSK0)
                  | is_reg(addr, pic_pkg::IDX_MSK1) | is_reg(addr, pic_pkg::IDX_MSK2)
                  | is_reg(addr, pic_pkg::IDX_MSK3) | is_reg(addr, pic_pkg::IDX_VC);
    endfunction

    // ************
    // pending and priority choice
    // ************
    assign pending = posted & irq_enable_regs & pic_pkg::SRC_VALID;

    pic_prio_enc #(
        .N     (NUM_PRIO),
        .IDX_W (pic_pkg::IDX_W)
    ) u_enc (
        .pending (pending),
        .found   (enc_found),
        .index   (enc_index)
    );

    // vector is four times the priority, zero when nothing pends
    assign cur_vector = enc_found ? {1'b0, enc_index, 2'b00} : 8'h00;

    // ************
    // register images in byte layout
    // ************
    always_comb begin
        for (int r = 0; r < 3; r++) begin
            clr_img[r] = 8'h00;
            msk_img[r] = 8'h00;
            for (int b = 0; b < 8; b++) begin
                if (pic_pkg::BYTE_MAP[r][b] != '0) begin
                    clr_img[r][b] = posted[pic_pkg::BYTE_MAP[r][b]];
                    msk_img[r][b] = irq_enable_regs[pic_pkg::BYTE_MAP[r][b]];
                end
            end
        end
    end

    // ************
    // software clear and post
    // ************
    assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
    assign wr_vc   = wr_fire & wr_lane & is_reg(wr_addr, pic_pkg::IDX_VC);

    always_comb begin
        sw_clr = '0;
        sw_set = '0;
        for (int r = 0; r < 3; r++) begin
            if (wr_fire && wr_lane && is_reg(wr_addr, pic_pkg::CLR_IDX[r])) begin
                for (int b = 0; b < 8; b++) begin
                    if (pic_pkg::BYTE_MAP[r][b] != '0) begin
                        if (soft_post_enable && wr_byte[b]) begin
                            sw_set[pic_pkg::BYTE_MAP[r][b]] = 1'b1;
                        end
                        if (!soft_post_enable && !wr_byte[b]) begin
                            sw_clr[pic_pkg::BYTE_MAP[r][b]] = 1'b1;
                        end
                    end
                end
            end
        end
    end

    // a vector register write drops everything that is pending now
    assign vc_clr = wr_vc ? pending : '0;

    always_comb begin
        ack_clr = '0;
        if (take_fire) begin
            ack_clr[enc_index] = 1'b1;
        end
    end

    // sets are applied last so an event never loses to a clear
    assign next_posted = ((posted & ~(sw_clr | vc_clr | ack_clr))
                         | src_event | sw_set) & pic_pkg::SRC_VALID;

    // ************
    // posted flags
    // ************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            posted <= '0;
        end else begin
            posted <= next_posted;
        end
    end

    // ************
    // mask registers
    // ************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_enable_regs  <= '0;
            soft_post_enable <= 1'b0;
        end else if (wr_fire && wr_lane) begin
            for (int r = 0; r < 3; r++) begin
                if (is_reg(wr_addr, pic_pkg::MSK_IDX[r])) begin
                    for (int b = 0; b < 8; b++) begin
                        if (pic_pkg::BYTE_MAP[r][b] != '0) begin
                            irq_enable_regs[pic_pkg::BYTE_MAP[r][b]] <= wr_byte[b];
                        end
                    end
                end
            end
            if (is_reg(wr_addr, pic_pkg::IDX_MSK3)) begin
                soft_post_enable <= wr_byte[pic_pkg::SOFT_POST_BIT];
            end
        end
    end

    // ************
    // request towards the cpu
    // ************
    // level follows posting, mask writes and enable rises alike
    assign irq_request = enc_found & cpu_flags[pic_pkg::GIE_BIT];
    assign boundary    = instr_done | return_from_irq_instr_done;
    // at return the restored flags decide, so waiting requests go first
    assign gie_now     = return_from_irq_instr_done ? return_from_irq_instr_flags[pic_pkg::GIE_BIT]
                                   : cpu_flags[pic_pkg::GIE_BIT];
    // no in-service lock: a set enable alone permits nesting
    assign take_fire   = (seq_state == pic_pkg::SEQ_IDLE) & boundary
                       & gie_now & enc_found;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_vector <= 8'h00;
        end else begin
            irq_vector <= cur_vector;
        end
    end

    // ************
    // dispatch sequencer
    // ************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            seq_state   <= pic_pkg::SEQ_IDLE;
            seq_cnt     <= '0;
            held_vector <= 8'h00;
            held_pc     <= 16'h0000;
            held_flags  <= 8'h00;
        end else begin
            unique case (seq_state)
                pic_pkg::SEQ_IDLE: begin
                    if (take_fire) begin
                        seq_state   <= pic_pkg::SEQ_DISPATCH;
                        seq_cnt     <= '0;
                        held_vector <= cur_vector;
                        held_pc     <= cpu_program_counter;
                        held_flags  <= return_from_irq_instr_done ? return_from_irq_instr_flags : cpu_flags;
                    end
                end
                pic_pkg::SEQ_DISPATCH: begin
                    if (seq_cnt == pic_pkg::DISPATCH_CYCLES - pic_pkg::CNT_ONE) begin
                        seq_state <= pic_pkg::SEQ_JUMP;
                        seq_cnt   <= '0;
                    end else begin
                        seq_cnt <= seq_cnt + pic_pkg::CNT_ONE;
                    end
                end
                pic_pkg::SEQ_JUMP: begin
                    if (seq_cnt == pic_pkg::LONG_JUMP_INSTR_CYCLES - pic_pkg::CNT_ONE) begin
                        seq_state <= pic_pkg::SEQ_IDLE;
                        seq_cnt   <= '0;
                    end else begin
                        seq_cnt <= seq_cnt + pic_pkg::CNT_ONE;
                    end
                end
                default: begin
                    seq_state <= pic_pkg::SEQ_IDLE;
                    seq_cnt   <= '0;
                end
            endcase
        end
    end

    // ************
    // registered cpu control strobes
    // ************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cpu_ctl <= '0;
        end else begin
            cpu_ctl             <= '0;
            cpu_ctl.dispatching <= (seq_state != pic_pkg::SEQ_IDLE) | take_fire;
            if (seq_state == pic_pkg::SEQ_DISPATCH) begin
                if (seq_cnt == pic_pkg::PUSH_PCH_CYC) begin
                    cpu_ctl.push_valid <= 1'b1;
                    cpu_ctl.push_data  <= held_pc[15:8];
                end
                if (seq_cnt == pic_pkg::PUSH_PCL_CYC) begin
                    cpu_ctl.push_valid <= 1'b1;
                    cpu_ctl.push_data  <= held_pc[7:0];
                end
                if (seq_cnt == pic_pkg::PUSH_FLAGS_CYC) begin
                    cpu_ctl.push_valid <= 1'b1;
                    cpu_ctl.push_data  <= held_flags;
                end
                if (seq_cnt == pic_pkg::FLAGS_CLR_CYC) begin
                    cpu_ctl.flags_clear <= 1'b1;
                end
                if (seq_cnt == pic_pkg::DISPATCH_CYCLES - pic_pkg::CNT_ONE) begin
                    cpu_ctl.pc_load  <= 1'b1;
                    cpu_ctl.pc_value <= {pic_pkg::PC_HIGH_ZERO, held_vector};
                end
            end
            if (seq_state == pic_pkg::SEQ_JUMP
                && seq_cnt == pic_pkg::LONG_JUMP_INSTR_CYCLES - pic_pkg::CNT_ONE) begin
                cpu_ctl.service_start <= 1'b1;
            end
        end
    end

    // ************
    // axi4-lite write channel
    // ************
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            wr_addr      <= '0;
            wr_byte      <= 8'h00;
            wr_lane      <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= pic_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held  <= 1'b1;
                wr_byte <= s_axi_wdata[7:0];
                wr_lane <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(wr_addr) ? pic_pkg::RESP_OKAY
                                                   : pic_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ************
    // axi4-lite read channel
    // ************
    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = is_mapped(s_axi_araddr);
        for (int r = 0; r < 3; r++) begin
            if (is_reg(s_axi_araddr, pic_pkg::CLR_IDX[r])) begin
                rd_byte = clr_img[r];
            end
            if (is_reg(s_axi_araddr, pic_pkg::MSK_IDX[r])) begin
                rd_byte = msk_img[r];
            end
        end
        if (is_reg(s_axi_araddr, pic_pkg::IDX_MSK3)) begin
            rd_byte[pic_pkg::SOFT_POST_BIT] = soft_post_enable;
        end
        if (is_reg(s_axi_araddr, pic_pkg::IDX_VC)) begin
            rd_byte = cur_vector;
        end
    end

    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= pic_pkg::RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h00_0000, rd_byte};
                s_axi_rresp  <= rd_hit ? pic_pkg::RESP_OKAY : pic_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // pic_ctrl

`default_nettype wire

// >>> test/pic_ctrl_chk.sv
// pic_ctrl_chk: dispatch sequence checks on the controller ports
// assumes: bound into pic_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl_chk (
    // clock, reset and cpu side
    input wire logic                  sys_clk,
    input wire logic                  rst,
    input wire logic                  instr_done,
    input wire logic                  return_from_irq_instr_done,
    input wire logic [7:0]            return_from_irq_instr_flags,
    input wire logic [7:0]            cpu_flags,
    input wire logic                  irq_request,
    input wire logic [7:0]            irq_vector,
    input wire pic_pkg::pic_cpu_ctl_t cpu_ctl
);
    // ****
    // checks
    // ****
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic gie_now;
    logic bound_now;
    // enable as the take edge sees it
    assign gie_now = return_from_irq_instr_done ? return_from_irq_instr_flags[0] : cpu_flags[0];
    assign bound_now = instr_done | return_from_irq_instr_done;
    stack_order_a: assert property ($rose(cpu_ctl.dispatching) |-> ##2
        cpu_ctl.push_valid [*3] ##1 cpu_ctl.flags_clear) else $error("bad stacking");
    dispatch_len_a: assert property ($rose(cpu_ctl.dispatching) |-> ##13
        cpu_ctl.pc_load ##7 cpu_ctl.service_start ##1 !cpu_ctl.dispatching)
        else $error("bad dispatch timing");
    take_cond_a: assert property ($rose(cpu_ctl.dispatching) |->
        $past(gie_now) && $past(bound_now)) else $error("take without cause");
    req_gate_a: assert property (irq_request |-> cpu_flags[0])
        else $error("request without enable");
    vec_align_a: assert property (irq_vector[1:0] == 2'h0 && irq_vector <= 8'h64)
        else $error("bad vector");
    pc_vector_a: assert property (cpu_ctl.pc_load |->
        cpu_ctl.pc_value[15:8] == 8'h00 && cpu_ctl.pc_value[1:0] == 2'h0) else $error("bad pc");
    push_inside_a: assert property (cpu_ctl.push_valid |-> cpu_ctl.dispatching)
        else $error("push outside dispatch");
    clear_last_a: assert property (cpu_ctl.flags_clear |=> !cpu_ctl.push_valid [*8])
        else $error("push after flag clear");
    cover property ($rose(cpu_ctl.dispatching));
    cover property (cpu_ctl.service_start);
    cover property (irq_request);
endmodule // pic_ctrl_chk
bind pic_ctrl pic_ctrl_chk pic_ctrl_chk_inst (.sys_clk, .rst, .instr_done, .return_from_irq_instr_done,
    .return_from_irq_instr_flags, .cpu_flags, .irq_request, .irq_vector, .cpu_ctl);
`default_nettype wire

// >>> test/pic_cpu_model.sv
// pic_cpu_model: cpu core stand-in that stacks pushes and keeps the enable
// assumes: enable set by the bench, no return instructions issued
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model (
    // clock, reset and controller side
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  gie_set,
    input  wire pic_pkg::pic_cpu_ctl_t cpu_ctl,
    output logic                       instr_done,
    output logic [7:0]                 cpu_flags,
    output logic [15:0]                cpu_program_counter,
    // what the core saw
    output logic [23:0]                stack_bytes,
    output logic [15:0]                pc_seen,
    output logic                       isr_seen
);
    // ****
    // core
    // ****
    // fixed pc keeps the stacked bytes predictable
    assign cpu_program_counter = 16'h1234;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {instr_done, cpu_flags, stack_bytes, pc_seen, isr_seen} <= '0;
        end else begin
            instr_done <= !instr_done && !cpu_ctl.dispatching;
            if (gie_set) cpu_flags <= 8'h01;
            if (cpu_ctl.flags_clear) cpu_flags <= 8'h00;
            if (cpu_ctl.push_valid) stack_bytes <= {stack_bytes[15:0], cpu_ctl.push_data};
            if (cpu_ctl.pc_load) pc_seen <= cpu_ctl.pc_value;
            if (cpu_ctl.service_start) isr_seen <= 1'b1;
        end
    end
endmodule // pic_cpu_model
`default_nettype wire

// >>> test/pic_ctrl_tb.sv
// pic_ctrl_tb: register and dispatch sequences against the controller
// assumes: cpu model on the core side, return path tied off
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl_tb;
    logic sys_clk = 1'b0, rst = 1'b1, gie_set = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [25:0] src_event = '0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic irq_request, instr_done, isr_seen;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] irq_vector, cpu_flags;
    logic [15:0] cpu_program_counter, pc_seen;
    logic [23:0] stack_bytes;
    pic_pkg::pic_cpu_ctl_t cpu_ctl;
    int mismatches = 0, checks = 0;
    pic_ctrl pic_ctrl_inst (.sys_clk, .rst, .src_event, .instr_done, .return_from_irq_instr_done(1'b0),
        .return_from_irq_instr_flags(8'h00), .cpu_flags, .cpu_program_counter, .irq_request, .irq_vector,
        .cpu_ctl, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp);
    pic_cpu_model pic_cpu_model_inst (.sys_clk, .rst, .gie_set, .cpu_ctl, .instr_done,
        .cpu_flags, .cpu_program_counter, .stack_bytes, .pc_seen, .isr_seen);
    always #25 sys_clk = ~sys_clk;
    // ****
    // tasks
    // ****
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic guard(input int n);
        if (n >= 50) begin
            mismatches++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        guard(n);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] r = 2'h0);
        int n;
        @(posedge sys_clk);
        s_axi_araddr <= {2'b00, idx, 2'b00};
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'b0;
        guard(n);
        chk("rdata", s_axi_rdata, e);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, r});
    endtask
    task automatic pulse(input logic [25:0] e, input logic g);
        @(posedge sys_clk);
        {src_event, gie_set} <= {e, g};
        @(posedge sys_clk);
        {src_event, gie_set} <= '0;
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ****
    // sequence
    // ****
    initial begin
        int i;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        for (i = 0; i < 3; i++) begin
            rd(pic_pkg::CLR_IDX[i], 32'h0);
            rd(pic_pkg::MSK_IDX[i], 32'h0);
        end
        // posting while masked: ext 0 and counter wrap
        pulse(26'h0020004, 1'b0);
        rd(pic_pkg::IDX_CLR0, 32'h02);
        rd(pic_pkg::IDX_CLR2, 32'h02);
        rd(pic_pkg::IDX_VC, 32'h0);
        wr(pic_pkg::IDX_MSK0, 32'h02);
        rd(pic_pkg::IDX_VC, 32'h08);
        wr(pic_pkg::IDX_MSK2, 32'h02);
        rd(pic_pkg::IDX_VC, 32'h08);
        wr(pic_pkg::IDX_CLR0, 32'h00);
        rd(pic_pkg::IDX_CLR0, 32'h00);
        rd(pic_pkg::IDX_VC, 32'h44);
        chk("vector", {24'h0, irq_vector}, 32'h44);
        chk("request", {31'h0, irq_request}, 32'h0);
        wr(pic_pkg::IDX_MSK3, 32'h80);
        wr(pic_pkg::IDX_CLR1, 32'h01);
        wr(pic_pkg::IDX_CLR2, 32'h00);
        rd(pic_pkg::IDX_CLR1, 32'h01);
        rd(pic_pkg::IDX_CLR2, 32'h02);
        wr(pic_pkg::IDX_VC, 32'h00);
        rd(pic_pkg::IDX_CLR2, 32'h00);
        rd(pic_pkg::IDX_CLR1, 32'h01);
        rd(8'h10, 32'h0, pic_pkg::RESP_SLVERR);
        // enable first, then unmask the posted endpoint to start dispatch
        pulse('0, 1'b1);
        wr(pic_pkg::IDX_MSK1, 32'h01);
        for (i = 0; i < 50 && isr_seen !== 1'b1; i++) @(posedge sys_clk);
        guard(i);
        chk("stack", {8'h00, stack_bytes}, 32'h00123401);
        chk("pc", {16'h0, pc_seen}, 32'h00000020);
        rd(pic_pkg::IDX_CLR1, 32'h00);
        wrap_up();
    end
endmodule // pic_ctrl_tb
`default_nettype wire
